// [sec_port_dma_pkg.sv]
// Constants, field layouts and carriers for the secondary port DMA address map.
// Assumes a single 20 MHz clock and a plain strobe register port.
package sec_port_dma_pkg;

  // Register port widths
  localparam int          REG_ADDR_W       = 4;
  localparam int          REG_DATA_W       = 16;

  // Register offsets
  localparam logic [3:0]  OFS_UPPER_OPND   = 4'h0;
  localparam logic [3:0]  OFS_LOWER_OPND   = 4'h1;
  localparam logic [3:0]  OFS_COMMAND      = 4'h2;
  localparam logic [3:0]  OFS_STATUS       = 4'h3;
  localparam logic [3:0]  OFS_WRITE_DATA   = 4'h4;
  localparam logic [3:0]  OFS_READ_DATA    = 4'h5;
  localparam logic [3:0]  OFS_ADDR_LOW     = 4'h6;
  localparam logic [3:0]  OFS_ADDR_HIGH    = 4'h7;

  // Reset values
  localparam logic [15:0] RST_OPERAND      = 16'h0000;
  localparam logic [15:0] RST_DATA         = 16'h0000;
  localparam logic [3:0]  IDLE_INDEX       = 4'h2;

  // Upper operand fields
  localparam int          MODE_BIT         = 7;
  localparam int          WAIT_HI          = 10;
  localparam int          WAIT_LO          = 8;
  localparam int          WAIT_W           = 3;
  localparam int          UP_ADDR_HI       = 4;
  localparam int          UP_INDEX_HI      = 6;
  localparam int          UP_INDEX_LO      = 5;

  // Lower operand fields
  localparam int          LO_ADDR_HI       = 15;
  localparam int          LO_ADDR_LO       = 5;
  localparam int          LO_INDEX_HI      = 4;
  localparam int          LO_INDEX_LO      = 1;

  // Command register fields
  localparam int          CMD_GO_BIT       = 0;
  localparam int          CMD_READ_BIT     = 1;

  // Status register fields
  localparam int          STS_BUSY_BIT     = 0;
  localparam int          STS_MODE_BIT     = 1;
  localparam int          STS_READ_BIT     = 2;
  localparam int          STS_DROP_BIT     = 3;
  localparam int          STS_WAIT_LO      = 4;

  // Address widths
  localparam int          BURST_ADDR_W     = 20;
  localparam int          NONBURST_ADDR_W  = 18;

  // Address index line roles in non-burst mode
  localparam int          IDX_STROBE_BIT   = 1;
  localparam int          IDX_LATCH_BIT    = 0;

  // Timing
  localparam int          CLOCK_PERIOD_NS  = 50;
  localparam int          LATCH_MIN_NS     = 50;
  localparam int          LATCH_CYCLES     = (LATCH_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int          SYNC_STAGES      = 2;

  // Pin carrier
  typedef struct packed {
    logic [15:0] addr_data;
    logic        addr_data_oe;
    logic [3:0]  addr_index;
    logic        transfer_mode;
  } pin_bundle_t;

endpackage : sec_port_dma_pkg

// [sec_port_dma_addr_map.sv]
// Secondary port DMA address former: operand registers, mode tag, pin drive.
// Assumes register strobes from logic on clock_in and pins from outside it.
`timescale 1ns/10ps

module sec_port_dma_addr_map #(
  parameter int WAIT_W = sec_port_dma_pkg::WAIT_W
) (
  input  wire logic                                  clock_in,
  input  wire logic                                  reset_n_in,
  input  wire logic [sec_port_dma_pkg::REG_ADDR_W-1:0] reg_addr_in,
  input  wire logic [sec_port_dma_pkg::REG_DATA_W-1:0] reg_wdata_in,
  input  wire logic                                  reg_write_in,
  input  wire logic                                  reg_read_in,
  output logic      [sec_port_dma_pkg::REG_DATA_W-1:0] reg_rdata_out,
  input  wire logic [15:0]                           sec_port_addr_data_bus_in,
  output logic      [15:0]                           sec_port_addr_data_bus_out,
  output logic                                       sec_port_addr_data_bus_oe_out,
  output logic      [3:0]                            sec_port_addr_index_out,
  output logic                                       sec_port_transfer_mode_out
);

  typedef enum {
    ST_IDLE,
    ST_ADDRESS,
    ST_ACCESS,
    ST_CAPTURE
  } state_t;

  state_t                  state_reg;
  logic [15:0]             upper_reg;
  logic [15:0]             lower_reg;
  logic [15:0]             wdata_reg;
  logic [15:0]             rdata_reg;
  logic                    mode_reg;
  logic                    read_dir_reg;
  logic                    drop_reg;
  logic [WAIT_W-1:0]       waits_reg;
  logic [WAIT_W:0]         count_reg;
  logic [15:0]             bus_meta_reg;
  logic [15:0]             bus_sync_reg;
  sec_port_dma_pkg::pin_bundle_t pins_reg;
  sec_port_dma_pkg::pin_bundle_t pins_next;
  logic                    go_write;
  logic                    go_accept;
  logic [19:0]             formed_addr;

  // Burst halfword address from the operands
  // Upper 4:0 as address 19:15
  function automatic logic [19:0] burst_addr(input logic [15:0] up, input logic [15:0] lo);
    burst_addr = {up[sec_port_dma_pkg::UP_ADDR_HI:0],
                  lo[sec_port_dma_pkg::LO_ADDR_HI:sec_port_dma_pkg::LO_ADDR_LO],
                  lo[sec_port_dma_pkg::LO_INDEX_HI:sec_port_dma_pkg::LO_INDEX_LO]};
  endfunction : burst_addr

  // Non-burst halfword address, zero extended to twenty bits
  // Upper 6:5 as address 17:16
  // Wait field and mode bit excluded
  function automatic logic [19:0] nonburst_addr(input logic [15:0] up, input logic [15:0] lo);
    nonburst_addr = {2'h0,
                     up[sec_port_dma_pkg::UP_INDEX_HI:sec_port_dma_pkg::UP_INDEX_LO],
                     up[sec_port_dma_pkg::UP_ADDR_HI:0],
                     lo[sec_port_dma_pkg::LO_ADDR_HI:sec_port_dma_pkg::LO_ADDR_LO]};
  endfunction : nonburst_addr

  // Address phase word for the multiplexed bus, same in both modes
  function automatic logic [15:0] bus_addr(input logic [15:0] up, input logic [15:0] lo);
    bus_addr = {up[sec_port_dma_pkg::UP_ADDR_HI:0],
                lo[sec_port_dma_pkg::LO_ADDR_HI:sec_port_dma_pkg::LO_ADDR_LO]};
  endfunction : bus_addr

  assign go_write  = reg_write_in && (reg_addr_in == sec_port_dma_pkg::OFS_COMMAND)
                     && reg_wdata_in[sec_port_dma_pkg::CMD_GO_BIT];
  assign go_accept = go_write && (state_reg == ST_IDLE);

  assign formed_addr = upper_reg[sec_port_dma_pkg::MODE_BIT] ? burst_addr(upper_reg, lower_reg)
                                                             : nonburst_addr(upper_reg, lower_reg);

  // Pad input synchroniser
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      bus_meta_reg <= sec_port_dma_pkg::RST_DATA;
      bus_sync_reg <= sec_port_dma_pkg::RST_DATA;
    end else begin
      bus_meta_reg <= sec_port_dma_port_in_guard(sec_port_addr_data_bus_in);
      bus_sync_reg <= bus_meta_reg;
    end
  end

  function automatic logic [15:0] sec_port_dma_port_in_guard(input logic [15:0] v);
    sec_port_dma_port_in_guard = v;
  endfunction : sec_port_dma_port_in_guard

  // Operand and write data registers
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      upper_reg <= sec_port_dma_pkg::RST_OPERAND;
      lower_reg <= sec_port_dma_pkg::RST_OPERAND;
      wdata_reg <= sec_port_dma_pkg::RST_DATA;
    end else if (reg_write_in) begin
      if (reg_addr_in == sec_port_dma_pkg::OFS_UPPER_OPND) begin
        upper_reg <= reg_wdata_in;
      end
      if (reg_addr_in == sec_port_dma_pkg::OFS_LOWER_OPND) begin
        lower_reg <= reg_wdata_in;
      end
      if (reg_addr_in == sec_port_dma_pkg::OFS_WRITE_DATA) begin
        wdata_reg <= reg_wdata_in;
      end
    end
  end

  // Active command stage
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      mode_reg     <= 1'b0;
      read_dir_reg <= 1'b0;
      waits_reg    <= '0;
    end else if (go_accept) begin
      mode_reg     <= reg_wdata_in[sec_port_dma_pkg::CMD_GO_BIT] & upper_reg[sec_port_dma_pkg::MODE_BIT];
      read_dir_reg <= reg_wdata_in[sec_port_dma_pkg::CMD_READ_BIT];
      waits_reg    <= upper_reg[sec_port_dma_pkg::WAIT_HI:sec_port_dma_pkg::WAIT_LO];
    end
  end

  // Dropped command flag, new drop wins over clear
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      drop_reg <= 1'b0;
    end else if (go_write && (state_reg != ST_IDLE)) begin
      drop_reg <= 1'b1;
    end else if (reg_write_in && (reg_addr_in == sec_port_dma_pkg::OFS_STATUS)
                 && reg_wdata_in[sec_port_dma_pkg::STS_DROP_BIT]) begin
      drop_reg <= 1'b0;
    end
  end

  // Transfer sequencer
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state_reg <= ST_IDLE;
      count_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (go_accept) begin
            state_reg <= ST_ADDRESS;
            count_reg <= (WAIT_W+1)'(sec_port_dma_pkg::LATCH_CYCLES - 1);
          end
        end
        ST_ADDRESS: begin
          if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
          end else if (mode_reg) begin
            state_reg <= ST_IDLE;
          end else begin
            // Zero waits gives one access cycle
            state_reg <= ST_ACCESS;
            count_reg <= {1'b0, waits_reg};
          end
        end
        ST_ACCESS: begin
          if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
          end else if (read_dir_reg) begin
            state_reg <= ST_CAPTURE;
            count_reg <= (WAIT_W+1)'(sec_port_dma_pkg::SYNC_STAGES - 1);
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_CAPTURE: begin
          if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          count_reg <= '0;
        end
      endcase
    end
  end

  // Read data capture once the pad value has settled
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      rdata_reg <= sec_port_dma_pkg::RST_DATA;
    end else if ((state_reg == ST_CAPTURE) && (count_reg == '0)) begin
      rdata_reg <= bus_sync_reg;
    end
  end

  // Next pin values
  always_comb begin
    pins_next               = pins_reg;
    pins_next.addr_data_oe  = 1'b0;
    pins_next.addr_data     = 16'h0000;
    pins_next.addr_index    = sec_port_dma_pkg::IDLE_INDEX;
    case (state_reg)
      ST_IDLE: begin
        if (go_accept) begin
          pins_next.transfer_mode = upper_reg[sec_port_dma_pkg::MODE_BIT];
          pins_next.addr_data_oe  = 1'b1;
          // Upper bits onto bus high lines
          // Lower bits onto bus low lines
          pins_next.addr_data     = bus_addr(upper_reg, lower_reg);
          if (upper_reg[sec_port_dma_pkg::MODE_BIT]) begin
            pins_next.addr_index = lower_reg[sec_port_dma_pkg::LO_INDEX_HI:sec_port_dma_pkg::LO_INDEX_LO];
          end else begin
            pins_next.addr_index[3:2] =
              upper_reg[sec_port_dma_pkg::UP_INDEX_HI:sec_port_dma_pkg::UP_INDEX_LO];
            pins_next.addr_index[sec_port_dma_pkg::IDX_STROBE_BIT] = 1'b1;
            pins_next.addr_index[sec_port_dma_pkg::IDX_LATCH_BIT]  = 1'b1;
          end
        end
      end
      ST_ADDRESS: begin
        if ((count_reg != '0) || mode_reg) begin
          pins_next.addr_data_oe = (count_reg != '0);
          pins_next.addr_data    = (count_reg != '0) ? pins_reg.addr_data : 16'h0000;
          pins_next.addr_index   = (count_reg != '0) ? pins_reg.addr_index : sec_port_dma_pkg::IDLE_INDEX;
        end else begin
          pins_next.addr_index[3:2] =
            upper_reg[sec_port_dma_pkg::UP_INDEX_HI:sec_port_dma_pkg::UP_INDEX_LO];
          // Strobe low on read, latch released
          pins_next.addr_index[sec_port_dma_pkg::IDX_STROBE_BIT] = ~read_dir_reg;
          pins_next.addr_index[sec_port_dma_pkg::IDX_LATCH_BIT]  = 1'b0;
          pins_next.addr_data_oe = ~read_dir_reg;
          pins_next.addr_data    = read_dir_reg ? 16'h0000 : wdata_reg;
        end
      end
      ST_ACCESS: begin
        if (count_reg != '0) begin
          pins_next.addr_data_oe = pins_reg.addr_data_oe;
          pins_next.addr_data    = pins_reg.addr_data;
          pins_next.addr_index   = pins_reg.addr_index;
        end
      end
      ST_CAPTURE: begin
        pins_next.addr_index = sec_port_dma_pkg::IDLE_INDEX;
      end
      default: begin
        pins_next.addr_index = sec_port_dma_pkg::IDLE_INDEX;
      end
    endcase
  end

  // Pin registers
  // Mode held with the pins
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      pins_reg.addr_data     <= 16'h0000;
      pins_reg.addr_data_oe  <= 1'b0;
      pins_reg.addr_index    <= sec_port_dma_pkg::IDLE_INDEX;
      pins_reg.transfer_mode <= 1'b0;
    end else begin
      pins_reg <= pins_next;
    end
  end

  assign sec_port_addr_data_bus_out    = pins_reg.addr_data;
  assign sec_port_addr_data_bus_oe_out = pins_reg.addr_data_oe;
  assign sec_port_addr_index_out       = pins_reg.addr_index;
  assign sec_port_transfer_mode_out    = pins_reg.transfer_mode;

  // Register read port, data in the cycle after the strobe
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        sec_port_dma_pkg::OFS_UPPER_OPND: reg_rdata_out <= upper_reg;
        sec_port_dma_pkg::OFS_LOWER_OPND: reg_rdata_out <= lower_reg;
        sec_port_dma_pkg::OFS_STATUS: begin
          reg_rdata_out <= {9'h000, waits_reg, drop_reg, read_dir_reg, mode_reg,
                            (state_reg != ST_IDLE)};
        end
        sec_port_dma_pkg::OFS_WRITE_DATA: reg_rdata_out <= wdata_reg;
        sec_port_dma_pkg::OFS_READ_DATA:  reg_rdata_out <= rdata_reg;
        sec_port_dma_pkg::OFS_ADDR_LOW:   reg_rdata_out <= formed_addr[15:0];
        sec_port_dma_pkg::OFS_ADDR_HIGH:  reg_rdata_out <= {12'h000, formed_addr[19:16]};
        default:                          reg_rdata_out <= 16'h0000;
      endcase
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

endmodule : sec_port_dma_addr_map

// [sec_port_dma_addr_map_unused.sv]
`timescale 1ns/10ps

// [sec_port_dma_addr_map_props.sv]
// Checker for the secondary port address former.
// Assumes only the top module ports; bound after the module.
`timescale 1ns/10ps
module sec_port_dma_addr_map_props #(parameter int WAIT_W = 3) (
  input wire logic        clock_in,
  input wire logic        reset_n_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [15:0] sec_port_addr_data_bus_in,
  input wire logic [15:0] sec_port_addr_data_bus_out,
  input wire logic        sec_port_addr_data_bus_oe_out,
  input wire logic [3:0]  sec_port_addr_index_out,
  input wire logic        sec_port_transfer_mode_out
);
  logic [15:0] up_reg, lo_reg, wd_reg, cu_reg, cl_reg, bus;
  logic [3:0]  rc_reg, wc_reg, idx;
  logic        oe, md, idle, go;
  assign bus = sec_port_addr_data_bus_out;
  assign idx = sec_port_addr_index_out;
  assign oe = sec_port_addr_data_bus_oe_out;
  assign md = sec_port_transfer_mode_out;
  assign idle = idx == 4'h2 && !oe;
  assign go = reg_write_in && reg_addr_in == 4'h2 && reg_wdata_in[0] && idle;
  // Shadow operands and launched command
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      up_reg <= '0;
      lo_reg <= '0;
      wd_reg <= '0;
      cu_reg <= '0;
      cl_reg <= '0;
    end else begin
      if (reg_write_in && reg_addr_in == 4'h0) up_reg <= reg_wdata_in;
      if (reg_write_in && reg_addr_in == 4'h1) lo_reg <= reg_wdata_in;
      if (reg_write_in && reg_addr_in == 4'h4) wd_reg <= reg_wdata_in;
      if (go) cu_reg <= up_reg;
      if (go) cl_reg <= lo_reg;
    end
  end
  // Wait phase lengths
  always_ff @(posedge clock_in) begin
    if (!reset_n_in || md) begin
      rc_reg <= '0;
      wc_reg <= '0;
    end else begin
      rc_reg <= (idx[1:0] == 2'b00 && !oe) ? rc_reg + 4'h1 : 4'h0;
      wc_reg <= (idx[1:0] == 2'b10 && oe) ? wc_reg + 4'h1 : 4'h0;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  chk_burst_addr: assert property (
    go && up_reg[7] |=> oe && md && bus == {cu_reg[4:0], cl_reg[15:5]} && idx == cl_reg[4:1]
    ##1 !oe && idx == 4'h2) else $error("burst address phase wrong");
  chk_nb_addr: assert property (
    go && !up_reg[7] |=> oe && !md && bus == {cu_reg[4:0], cl_reg[15:5]} && idx == {cu_reg[6:5], 2'b11})
    else $error("non-burst address phase wrong");
  chk_mode_tag: assert property (go |=> md == cu_reg[7]) else $error("mode tag wrong");
  chk_mode_hold: assert property (idle && $past(idle) |-> $stable(md)) else $error("mode moved");
  chk_read_waits: assert property (
    rc_reg != 4'h0 && !(idx[1:0] == 2'b00 && !oe) |-> rc_reg == {1'b0, cu_reg[10:8]} + 4'h1)
    else $error("read wait count wrong");
  chk_write_waits: assert property (
    wc_reg != 4'h0 && !(idx[1:0] == 2'b10 && oe) |-> wc_reg == {1'b0, cu_reg[10:8]} + 4'h1)
    else $error("write wait count wrong");
  chk_write_data: assert property (
    !md && oe && idx[1:0] == 2'b10 |-> bus == wd_reg) else $error("write data wrong");
  chk_addr_low: assert property (
    reg_read_in && reg_addr_in == 4'h6 |=> reg_rdata_out ==
    (up_reg[7] ? {up_reg[0], lo_reg[15:1]} : {up_reg[4:0], lo_reg[15:5]})) else $error("address low wrong");
  chk_addr_high: assert property (
    reg_read_in && reg_addr_in == 4'h7 |=> reg_rdata_out ==
    (up_reg[7] ? {12'h000, up_reg[4:1]} : {14'h0000, up_reg[6:5]})) else $error("address high wrong");
endmodule : sec_port_dma_addr_map_props

bind sec_port_dma_addr_map sec_port_dma_addr_map_props #(.WAIT_W(WAIT_W)) u_props (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
  .reg_rdata_out(reg_rdata_out), .sec_port_addr_data_bus_in(sec_port_addr_data_bus_in),
  .sec_port_addr_data_bus_out(sec_port_addr_data_bus_out),
  .sec_port_addr_data_bus_oe_out(sec_port_addr_data_bus_oe_out),
  .sec_port_addr_index_out(sec_port_addr_index_out), .sec_port_transfer_mode_out(sec_port_transfer_mode_out));

// [ext_mem_model.sv]
// Far-side memory answering non-burst reads.
// Assumes pin outputs of the address former on one clock.
`timescale 1ns/10ps
module ext_mem_model #(parameter logic [15:0] READ_WORD = 16'h5A3C) (
  input  wire logic        clock_in,
  input  wire logic [3:0]  index_in,
  input  wire logic        oe_in,
  input  wire logic        mode_in,
  output logic      [15:0] data_out
);
  logic [1:0] hold_reg;
  logic       strobe;
  initial hold_reg = 2'h0;
  assign strobe = !mode_in && !oe_in && !index_in[1];
  // Answer while read strobe is low and for three cycles after release, inverse after that
  assign data_out = (strobe || hold_reg != 2'h0) ? READ_WORD : ~READ_WORD;
  always @(posedge clock_in) begin
    if (strobe) begin
      hold_reg <= 2'h3;
    end else if (hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
    end
  end
endmodule : ext_mem_model

// [tb_top.sv]
// Self-checking bench for the secondary port address former.
// Assumes package, design, checker and far-side model compiled first.
`timescale 1ns/10ps
module tb_top;
  logic        clock_in, reset_n_in, reg_write_in, reg_read_in, oe, mode;
  logic [3:0]  reg_addr_in, idx;
  logic [15:0] reg_wdata_in, rdata, bus_out, mdl_data, pad, rd_val;
  int          errors, tests_run;
  assign pad = oe ? bus_out : mdl_data;
  sec_port_dma_addr_map u_sec_port_dma_addr_map (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(rdata), .sec_port_addr_data_bus_in(pad),
    .sec_port_addr_data_bus_out(bus_out), .sec_port_addr_data_bus_oe_out(oe),
    .sec_port_addr_index_out(idx), .sec_port_transfer_mode_out(mode));
  ext_mem_model u_ext_mem_model (.clock_in(clock_in), .index_in(idx), .oe_in(oe), .mode_in(mode),
    .data_out(mdl_data));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_in);
    reg_write_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clock_in);
    reg_read_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    #1;
    rd_val = rdata;
  endtask : reg_rd
  task automatic wait_idle();
    int n;
    n = 0;
    reg_rd(4'h3);
    while (rd_val[0] !== 1'b0 && n < 40) begin
      n++;
      reg_rd(4'h3);
    end
    check("busy", {15'h0, rd_val[0]}, 16'h0000);
  endtask : wait_idle
  task automatic t_reset();
    logic [3:0] ofs [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
    #1;
    check("idle pins", {idx, 11'h0, oe}, 16'h2000);
    foreach (ofs[i]) begin
      reg_rd(ofs[i]);
      check("reset read", rd_val, 16'h0000);
    end
  endtask : t_reset
  task automatic t_burst(input logic [15:0] up, input logic [15:0] lo);
    reg_wr(4'h0, up);
    reg_wr(4'h1, lo);
    reg_rd(4'h6);
    check("burst addr low", rd_val, {up[0], lo[15:1]});
    reg_rd(4'h7);
    check("burst addr high", rd_val, {12'h000, up[4:1]});
    reg_wr(4'h2, 16'h0001);
    #1;
    check("burst bus", bus_out, {up[4:0], lo[15:5]});
    check("burst index", {12'h000, idx}, {12'h000, lo[4:1]});
    check("burst mode", {14'h0, oe, mode}, 16'h0003);
    @(posedge clock_in);
    #1;
    check("burst release", {12'h000, idx}, 16'h0002);
    wait_idle();
  endtask : t_burst
  task automatic t_nb_write(input logic [2:0] w);
    logic [15:0] up;
    int n;
    up = {5'h1F, w, 1'b0, 2'b10, 5'h0B};
    reg_wr(4'h0, up);
    reg_wr(4'h1, 16'h8421);
    reg_wr(4'h4, 16'hC3A5);
    reg_rd(4'h6);
    check("nb addr low", rd_val, {up[4:0], 11'h421});
    reg_rd(4'h7);
    check("nb addr high", rd_val, {14'h0, up[6:5]});
    reg_wr(4'h2, 16'h0001);
    #1;
    check("nb bus", bus_out, {up[4:0], 11'h421});
    check("nb index", {11'h000, idx, mode}, {11'h000, up[6:5], 3'b110});
    n = 0;
    while (oe === 1'b1 && n < 20) begin
      n++;
      @(posedge clock_in);
      #1;
    end
    check("write cycles", 16'(n), 16'(w) + 16'h2);
    wait_idle();
  endtask : t_nb_write
  task automatic t_nb_read(input logic [15:0] up);
    reg_wr(4'h0, up);
    reg_wr(4'h1, 16'h7FE0);
    reg_wr(4'h2, 16'h0003);
    #1;
    check("read latch", {12'h000, idx}, {12'h000, up[6:5], 2'b11});
    @(posedge clock_in);
    #1;
    check("read strobe", {11'h000, idx, oe}, {11'h000, up[6:5], 3'b000});
    wait_idle();
    reg_rd(4'h5);
    check("read data", rd_val, 16'h5A3C);
  endtask : t_nb_read
  task automatic t_drop();
    reg_wr(4'h0, 16'h0700);
    reg_wr(4'h2, 16'h0001);
    reg_wr(4'h2, 16'h0001);
    reg_rd(4'h3);
    check("drop flag", rd_val & 16'h000B, 16'h0009);
    wait_idle();
    reg_wr(4'h3, 16'h0008);
    reg_rd(4'h3);
    check("drop clear", rd_val & 16'h0008, 16'h0000);
  endtask : t_drop
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  initial begin
    reset_n_in = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 16'h0000;
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (5) @(posedge clock_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_burst(16'hFF95, 16'hABCD);
    t_burst(16'h0080, 16'h0001);
    t_nb_write(3'h0);
    t_nb_write(3'h7);
    t_nb_read(16'h0033);
    t_nb_read(16'h0233);
    t_drop();
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clock_in);
    errors++;
    give_verdict();
  end
endmodule : tb_top
